// ===== src/cmp_pkg.sv
// constants for the comparator control block: register map, field layout, reset values, timing
// assumes a 25 MHz peripheral clock and a 32-bit avalon-mm register port
package cmp_pkg;
	localparam int CLK_HZ = 25_000_000;
	localparam int ADDR_W = 4;
	// byte offsets of the registers
	localparam logic [ADDR_W-1:0] OFS_CTRL = 4'h0;
	localparam logic [ADDR_W-1:0] OFS_MUX = 4'h2;
	localparam logic [ADDR_W-1:0] OFS_REF = 4'h4;
	localparam logic [ADDR_W-1:0] OFS_IRQ = 4'h6;
	localparam logic [ADDR_W-1:0] OFS_STAT = 4'h7;
	// field positions in the first control register
	localparam int CTRL_EN_BIT = 0;
	localparam int CTRL_HYS_LSB = 1;
	localparam int CTRL_LP_BIT = 3;
	localparam int CTRL_EDGE_LSB = 4;
	localparam int CTRL_PAD_BIT = 6;
	localparam int CTRL_STBY_BIT = 7;
	// field positions in the input selector register
	localparam int MUX_NEG_LSB = 0;
	localparam int MUX_POS_LSB = 3;
	localparam int MUX_INV_BIT = 7;
	// status and interrupt enable registers
	localparam int STAT_FLAG_BIT = 0;
	localparam int STAT_STATE_BIT = 4;
	localparam int IRQ_EN_BIT = 0;
	// reset values
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [7:0] MUX_RST = 8'h00;
	localparam logic [7:0] REF_RST = 8'hff;
	localparam logic [7:0] IRQ_RST = 8'h00;
	// edge select codes
	localparam logic [1:0] EDGE_ANY = 2'h0;
	localparam logic [1:0] EDGE_FALL = 2'h2;
	localparam logic [1:0] EDGE_RISE = 2'h3;
	// hysteresis codes
	localparam logic [1:0] HYS_NONE = 2'h0;
	localparam logic [1:0] HYS_LARGE = 2'h3;
	// start-up time in ns, longest time so rounded down
	localparam int STARTUP_NS = 2500;
	localparam int STARTUP_CYC = (STARTUP_NS * (CLK_HZ / 1_000_000)) / 1000;
	localparam int SYNC_STAGES = 3;
	// power states from the system
	typedef enum logic [1:0]
	{
		PWR_ACTIVE = 2'h0,
		PWR_IDLE = 2'h1,
		PWR_STANDBY = 2'h2,
		PWR_DOWN = 2'h3
	} cmp_power_type;
endpackage : cmp_pkg

// ===== src/cmp_sync.sv
// multi-stage synchroniser for the gated and optionally inverted comparator level
// assumes the input is asynchronous to clk_in
`timescale 1ns/100ps
module cmp_sync #(
	parameter int STAGES = 3
) (
	// clock and reset
	input wire logic clk_in,
	input wire logic nrst_in,
	// level
	input wire logic async_in,
	output logic sync_out
);
	logic [STAGES-1:0] chain_r;
	logic [STAGES-1:0] chain_nxt;

	always_comb
	begin
		chain_nxt = {chain_r[STAGES-2:0], async_in};
	end

	always_ff @(posedge clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
			chain_r <= '0;
		else
			chain_r <= chain_nxt;
	end

	assign sync_out = chain_r[STAGES-1];
endmodule : cmp_sync

// ===== src/cmp_ctrl.sv
// digital control and status around an analog voltage comparator
// assumes the analog core delivers the raw compare level asynchronously and reads the analog settings
//
// The implementer's own choices: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/100ps
module cmp_ctrl #(
	parameter int STARTUP_CYCLES = cmp_pkg::STARTUP_CYC
) (
	// clock and reset
	input wire logic clk_in,
	input wire logic nrst_in,
	// avalon-mm slave
	input wire logic [cmp_pkg::ADDR_W-1:0] avs_address_in,
	input wire logic avs_read_in,
	input wire logic avs_write_in,
	input wire logic [31:0] avs_writedata_in,
	input wire logic [3:0] avs_byteenable_in,
	output logic [31:0] avs_readdata_out,
	output logic avs_waitrequest_out,
	// system power state
	input wire logic [1:0] power_state_in,
	// analog core
	input wire logic raw_compare_in,
	output logic analog_enable_out,
	output logic [1:0] positive_input_select_out,
	output logic [1:0] negative_input_select_out,
	output logic [1:0] hysteresis_select_out,
	output logic low_current_select_out,
	output logic [7:0] internal_reference_divider_out,
	// consumers
	output logic event_level_out,
	output logic pad_out,
	output logic pad_oe_out,
	output logic result_valid_out,
	output logic irq_out
);
	////////////////////////////////////////////////////////////////
	// registers
	logic [7:0] ctrl_r;
	logic [7:0] ctrl_nxt;
	logic [7:0] mux_r;
	logic [7:0] mux_nxt;
	logic [7:0] ref_r;
	logic [7:0] ref_nxt;
	logic irq_en_r;
	logic irq_en_nxt;
	logic flag_r;
	logic flag_nxt;
	logic [31:0] rdata_r;
	logic [31:0] rdata_nxt;
	logic ack_r;
	logic ack_nxt;
	logic prev_r;
	logic prev_nxt;
	logic [15:0] start_cnt_r;
	logic [15:0] start_cnt_nxt;
	logic running;
	logic result;
	logic result_sync;
	logic edge_hit;
	logic wr_take;
	logic rd_take;
	logic pwr_down;

	////////////////////////////////////////////////////////////////
	// run gating from enable and sleep state
	always_comb
	begin
		pwr_down = (power_state_in == cmp_pkg::PWR_DOWN);
		case (power_state_in)
			cmp_pkg::PWR_ACTIVE,
			cmp_pkg::PWR_IDLE: running = ctrl_r[cmp_pkg::CTRL_EN_BIT];
			cmp_pkg::PWR_STANDBY: running = ctrl_r[cmp_pkg::CTRL_EN_BIT] && ctrl_r[cmp_pkg::CTRL_STBY_BIT];
			cmp_pkg::PWR_DOWN: running = 1'b0;
			default: running = 1'b0;
		endcase
	end

	// analog settings go straight to the core; the core compares and its level comes back
	assign analog_enable_out = running;
	assign positive_input_select_out = mux_r[cmp_pkg::MUX_POS_LSB +: 2];
	assign negative_input_select_out = mux_r[cmp_pkg::MUX_NEG_LSB +: 2];
	assign hysteresis_select_out = ctrl_r[cmp_pkg::CTRL_HYS_LSB +: 2];
	assign low_current_select_out = ctrl_r[cmp_pkg::CTRL_LP_BIT];
	assign internal_reference_divider_out = ref_r;

	// combinational path so the event keeps working with the clock stopped in standby
	assign result = running && (raw_compare_in ^ mux_r[cmp_pkg::MUX_INV_BIT]);
	assign event_level_out = result;
	assign pad_oe_out = ctrl_r[cmp_pkg::CTRL_PAD_BIT] && !pwr_down;
	assign pad_out = result && pad_oe_out;

	////////////////////////////////////////////////////////////////
	// synchroniser for state bit and edge detection
	cmp_sync #(
		.STAGES(cmp_pkg::SYNC_STAGES)
	) u_sync (
		.clk_in(clk_in),
		.nrst_in(nrst_in),
		.async_in(result),
		.sync_out(result_sync)
	);

	////////////////////////////////////////////////////////////////
	// bus slave: one wait cycle, answer on the second edge
	// read data is loaded at the request edge so it already stands when waitrequest drops
	always_comb
	begin
		wr_take = avs_write_in && ack_r;
		rd_take = avs_read_in && !ack_r;
	end
	assign avs_waitrequest_out = (avs_read_in || avs_write_in) && !ack_r;
	assign avs_readdata_out = rdata_r;

	function automatic logic [7:0] merge_byte(input logic [7:0] old_v, input logic [31:0] wd,
		input logic [3:0] be, input logic [cmp_pkg::ADDR_W-1:0] adr);
		logic [1:0] lane;
		lane = adr[1:0];
		merge_byte = be[lane] ? wd[8*lane +: 8] : old_v;
	endfunction : merge_byte

	function automatic logic lane_on(input logic [3:0] be, input logic [cmp_pkg::ADDR_W-1:0] adr);
		lane_on = be[adr[1:0]];
	endfunction : lane_on

	////////////////////////////////////////////////////////////////
	// register, flag and start-up next state
	always_comb
	begin
		ctrl_nxt = ctrl_r;
		mux_nxt = mux_r;
		ref_nxt = ref_r;
		irq_en_nxt = irq_en_r;
		flag_nxt = flag_r;
		rdata_nxt = rdata_r;
		ack_nxt = (avs_read_in || avs_write_in) && !ack_r;
		prev_nxt = result_sync;
		start_cnt_nxt = start_cnt_r;
		edge_hit = 1'b0;
		if (wr_take)
		begin
			case (avs_address_in)
				cmp_pkg::OFS_CTRL: ctrl_nxt = merge_byte(ctrl_r, avs_writedata_in, avs_byteenable_in, avs_address_in);
				cmp_pkg::OFS_MUX: mux_nxt = merge_byte(mux_r, avs_writedata_in, avs_byteenable_in, avs_address_in) & 8'h9b;
				cmp_pkg::OFS_REF: ref_nxt = merge_byte(ref_r, avs_writedata_in, avs_byteenable_in, avs_address_in);
				cmp_pkg::OFS_IRQ:
					if (lane_on(avs_byteenable_in, avs_address_in))
						irq_en_nxt = avs_writedata_in[8*avs_address_in[1:0] + cmp_pkg::IRQ_EN_BIT];
				cmp_pkg::OFS_STAT:
					if (lane_on(avs_byteenable_in, avs_address_in) &&
						avs_writedata_in[8*avs_address_in[1:0] + cmp_pkg::STAT_FLAG_BIT])
						flag_nxt = 1'b0;
				default: ;
			endcase
		end
		// edge detect on the synchronised level, only while running
		if (running)
		begin
			case (ctrl_r[cmp_pkg::CTRL_EDGE_LSB +: 2])
				cmp_pkg::EDGE_ANY: edge_hit = result_sync ^ prev_r;
				cmp_pkg::EDGE_FALL: edge_hit = prev_r && !result_sync;
				cmp_pkg::EDGE_RISE: edge_hit = !prev_r && result_sync;
				default: edge_hit = 1'b0; // reserved code raises nothing
			endcase
		end
		// set wins over a clear in the same cycle
		if (edge_hit)
			flag_nxt = 1'b1;
		// start-up count restarts whenever the comparator stops
		if (!running)
			start_cnt_nxt = 16'(STARTUP_CYCLES);
		else if (start_cnt_r != 16'h0000)
			start_cnt_nxt = start_cnt_r - 16'h0001;
		if (rd_take)
		begin
			rdata_nxt = 32'h0000_0000;
			case (avs_address_in)
				cmp_pkg::OFS_CTRL: rdata_nxt[8*avs_address_in[1:0] +: 8] = ctrl_r;
				cmp_pkg::OFS_MUX: rdata_nxt[8*avs_address_in[1:0] +: 8] = mux_r;
				cmp_pkg::OFS_REF: rdata_nxt[8*avs_address_in[1:0] +: 8] = ref_r;
				cmp_pkg::OFS_IRQ: rdata_nxt[8*avs_address_in[1:0] + cmp_pkg::IRQ_EN_BIT] = irq_en_r;
				cmp_pkg::OFS_STAT:
				begin
					rdata_nxt[8*avs_address_in[1:0] + cmp_pkg::STAT_FLAG_BIT] = flag_r;
					rdata_nxt[8*avs_address_in[1:0] + cmp_pkg::STAT_STATE_BIT] = result_sync;
				end
				default: rdata_nxt = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			ctrl_r <= cmp_pkg::CTRL_RST;
			mux_r <= cmp_pkg::MUX_RST;
			ref_r <= cmp_pkg::REF_RST;
			irq_en_r <= cmp_pkg::IRQ_RST[0];
			flag_r <= 1'b0;
			rdata_r <= 32'h0000_0000;
			ack_r <= 1'b0;
			prev_r <= 1'b0;
			start_cnt_r <= 16'h0000;
		end
		else
		begin
			ctrl_r <= ctrl_nxt;
			mux_r <= mux_nxt;
			ref_r <= ref_nxt;
			irq_en_r <= irq_en_nxt;
			flag_r <= flag_nxt;
			rdata_r <= rdata_nxt;
			ack_r <= ack_nxt;
			prev_r <= prev_nxt;
			start_cnt_r <= start_cnt_nxt;
		end
	end

	////////////////////////////////////////////////////////////////
	// outputs
	// an internal reference may need longer than this count; software must allow for it
	assign result_valid_out = running && (start_cnt_r == 16'h0000);
	assign irq_out = irq_en_r && flag_r;
endmodule : cmp_ctrl

// ===== testbench/cmp_analog_model.sv
// model of the analog core: seven pin levels compared through the selectors
// assumes the bench drives the pin levels, positive pins in bytes 0-3, negative in 4-6
`timescale 1ns/100ps
module cmp_analog_model (
	// settings from the block
	input wire logic en_in,
	input wire logic [1:0] pos_in,
	input wire logic [1:0] neg_in,
	input wire logic [7:0] ref_in,
	// levels
	input wire logic [55:0] pins_in,
	// result
	output logic raw_out
);
	logic [7:0] vp;
	logic [7:0] vn;
	assign vp = pins_in[8*pos_in +: 8];
	assign vn = (neg_in == 2'h3) ? ref_in : pins_in[32+8*neg_in +: 8];
	// a core that is off shows the opposite level, never a kind stale one
	assign raw_out = en_in ? (vp > vn) : (vp <= vn);
endmodule : cmp_analog_model

// ===== testbench/cmp_ctrl_asserts.sv
// port-level checker for cmp_ctrl
// assumes one clock domain and the bind at the foot of this file
`timescale 1ns/100ps
module cmp_ctrl_asserts #(
	parameter int STARTUP_CYCLES = 4
) (
	input wire logic clk_in,
	input wire logic nrst_in,
	input wire logic [cmp_pkg::ADDR_W-1:0] avs_address_in,
	input wire logic avs_read_in,
	input wire logic avs_write_in,
	input wire logic avs_waitrequest_out,
	input wire logic raw_compare_in,
	input wire logic [1:0] power_state_in,
	input wire logic analog_enable_out,
	input wire logic event_level_out,
	input wire logic pad_out,
	input wire logic pad_oe_out,
	input wire logic result_valid_out,
	input wire logic irq_out
);
	localparam int SU_MAX = STARTUP_CYCLES + 4;
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!nrst_in);
	////////////////////////////////////////////////////////////////
	sequence s_req;
		(avs_read_in || avs_write_in) && avs_waitrequest_out;
	endsequence
	sequence s_take;
		!avs_waitrequest_out;
	endsequence
	property p_answer; s_req |=> s_take; endproperty
	a_answer: assert property (p_answer) else $error("no answer one cycle after request");
	property p_off; !analog_enable_out |-> !event_level_out && !result_valid_out; endproperty
	a_off: assert property (p_off) else $error("output active while core off");
	property p_pad; pad_out == (event_level_out && pad_oe_out); endproperty
	a_pad: assert property (p_pad) else $error("pad does not follow result");
	property p_down; power_state_in == 2'h3 |-> !analog_enable_out && !pad_oe_out; endproperty
	a_down: assert property (p_down) else $error("active in power-down");
	property p_su_low; $rose(analog_enable_out) |-> !result_valid_out ##1 !result_valid_out; endproperty
	a_su_low: assert property (p_su_low) else $error("valid during start-up");
	property p_su_end; $rose(analog_enable_out) |-> ##[1:SU_MAX] (result_valid_out || !analog_enable_out); endproperty
	a_su_end: assert property (p_su_end) else $error("start-up never ends");
	property p_follow;
		$changed(raw_compare_in) && analog_enable_out && $stable(analog_enable_out) && !$past(avs_write_in)
			|-> $changed(event_level_out);
	endproperty
	a_follow: assert property (p_follow) else $error("event misses a result change");
	property p_irq_hold; $fell(irq_out) |-> $past(avs_write_in); endproperty
	a_irq_hold: assert property (p_irq_hold) else $error("request dropped without a write");
endmodule : cmp_ctrl_asserts
bind cmp_ctrl cmp_ctrl_asserts #(.STARTUP_CYCLES(STARTUP_CYCLES)) u_chk (.*);

// ===== testbench/cmp_ctrl_tb.sv
// self-checking bench for cmp_ctrl with the analog core model
// assumes a short start-up count so the run stays small
`timescale 1ns/100ps
module cmp_ctrl_tb;
	localparam int SU = 4;
	logic clk_in = 1'b0;
	logic nrst_in = 1'b0;
	logic [3:0] adr = 4'h0;
	logic rd = 1'b0;
	logic wr = 1'b0;
	logic [31:0] wdata = 32'h0000_0000;
	logic [3:0] be = 4'h0;
	logic [1:0] pst = 2'h0;
	logic [55:0] pins = 56'h0000_8080_8040_4040;
	logic [31:0] rdata;
	logic wreq, raw, an, ev, pad, oe, vld, irq, lp;
	logic [1:0] ps, ns, hy;
	logic [7:0] rf;
	int n_fail = 0;
	int checks = 0;
	always #20 clk_in = ~clk_in;
	cmp_ctrl #(.STARTUP_CYCLES(SU)) dut (.clk_in(clk_in), .nrst_in(nrst_in), .avs_address_in(adr),
		.avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdata), .avs_byteenable_in(be),
		.avs_readdata_out(rdata), .avs_waitrequest_out(wreq), .power_state_in(pst), .raw_compare_in(raw),
		.analog_enable_out(an), .positive_input_select_out(ps), .negative_input_select_out(ns),
		.hysteresis_select_out(hy), .low_current_select_out(lp), .internal_reference_divider_out(rf),
		.event_level_out(ev), .pad_out(pad), .pad_oe_out(oe), .result_valid_out(vld), .irq_out(irq));
	cmp_analog_model u_core (.en_in(an), .pos_in(ps), .neg_in(ns), .ref_in(rf), .pins_in(pins), .raw_out(raw));
	////////////////////////////////////////////////////////////////
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		checks++;
		if (g !== e)
		begin
			n_fail++;
			$display("MISMATCH %s exp %h got %h", nm, e, g);
		end
	endtask : chk
	// request held until the edge where waitrequest is seen low
	task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d, output logic [7:0] q);
		int n;
		n = 0;
		@(posedge clk_in);
		adr <= a;
		wdata <= {4{d}};
		be <= 4'h1 << a[1:0];
		wr <= w;
		rd <= !w;
		do
		begin
			@(posedge clk_in);
			n++;
		end
		while (wreq !== 1'b0 && n < 20);
		if (wreq !== 1'b0)
			n_fail++;
		q = 8'(rdata >> (8 * a[1:0]));
		wr <= 1'b0;
		rd <= 1'b0;
	endtask : bus
	// outputs are looked at once the written value has settled
	task automatic wreg(input logic [3:0] a, input logic [7:0] d);
		logic [7:0] q;
		bus(1'b1, a, d, q);
		@(negedge clk_in);
	endtask : wreg
	task automatic rchk(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
		logic [7:0] q;
		bus(1'b0, a, 8'h00, q);
		chk("register", e, q & m);
	endtask : rchk
	// positive pin 0 level; negative pin 0 sits at 0x80, then the synchroniser settles
	task automatic lvl(input logic [7:0] v);
		@(posedge clk_in);
		pins[7:0] <= v;
		repeat (8) @(posedge clk_in);
		@(negedge clk_in);
	endtask : lvl
	task automatic pwr(input logic [1:0] s, input logic [2:0] e);
		@(posedge clk_in);
		pst <= s;
		@(negedge clk_in);
		chk("core,event,pad_oe", 8'(e), {5'h00, an, ev, oe});
	endtask : pwr
	////////////////////////////////////////////////////////////////
	task automatic t_reset;
		rchk(cmp_pkg::OFS_CTRL, 8'hff, 8'h00);
		rchk(cmp_pkg::OFS_MUX, 8'hff, 8'h00);
		rchk(cmp_pkg::OFS_REF, 8'hff, 8'hff);
		rchk(cmp_pkg::OFS_IRQ, 8'hff, 8'h00);
		rchk(cmp_pkg::OFS_STAT, 8'hff, 8'h00);
		rchk(4'h9, 8'hff, 8'h00);
	endtask : t_reset
	task automatic t_config;
		wreg(cmp_pkg::OFS_MUX, 8'h1b);
		wreg(cmp_pkg::OFS_REF, 8'h55);
		@(posedge clk_in);
		pins[31:24] <= 8'h60;
		wreg(cmp_pkg::OFS_CTRL, 8'h4f);
		chk("valid early", 8'h00, 8'(vld));
		chk("sel,hys,lp", 8'hfe, {ps, ns, hy, lp, 1'b0});
		chk("ref", 8'h55, rf);
		repeat (SU + 3) @(posedge clk_in);
		@(negedge clk_in);
		chk("valid,event,pad", 8'h07, {5'h00, vld, ev, pad});
		rchk(cmp_pkg::OFS_STAT, 8'h10, 8'h10);
		wreg(cmp_pkg::OFS_MUX, 8'h9b);
		chk("inverted event,pad", 8'h00, {6'h00, ev, pad});
		wreg(cmp_pkg::OFS_MUX, 8'h00);
	endtask : t_config
	task automatic t_edges;
		logic [1:0] c;
		for (int i = 0; i < 4; i++)
		begin
			c = (i == 3) ? 2'h1 : 2'(i + 1);
			c = (i == 0) ? 2'h0 : c;
			wreg(cmp_pkg::OFS_CTRL, {2'b00, c, 4'h1});
			lvl(8'h40);
			wreg(cmp_pkg::OFS_STAT, 8'h01);
			lvl(8'hc0);
			rchk(cmp_pkg::OFS_STAT, 8'h11, {7'h08, c == 2'h0 || c == 2'h3});
			chk("irq masked", 8'h00, 8'(irq));
			wreg(cmp_pkg::OFS_STAT, 8'h01);
			lvl(8'h40);
			rchk(cmp_pkg::OFS_STAT, 8'h11, {7'h00, c == 2'h0 || c == 2'h2});
		end
	endtask : t_edges
	task automatic t_irq;
		wreg(cmp_pkg::OFS_CTRL, 8'h01);
		wreg(cmp_pkg::OFS_IRQ, 8'h01);
		wreg(cmp_pkg::OFS_STAT, 8'h01);
		lvl(8'hc0);
		chk("irq set", 8'h01, 8'(irq));
		wreg(cmp_pkg::OFS_STAT, 8'h00);
		chk("irq kept", 8'h01, 8'(irq));
		wreg(cmp_pkg::OFS_STAT, 8'h01);
		chk("irq cleared", 8'h00, 8'(irq));
		wreg(cmp_pkg::OFS_IRQ, 8'h00);
	endtask : t_irq
	task automatic t_power;
		wreg(cmp_pkg::OFS_CTRL, 8'h41);
		pwr(cmp_pkg::PWR_IDLE, 3'h7);
		pwr(cmp_pkg::PWR_STANDBY, 3'h1);
		wreg(cmp_pkg::OFS_CTRL, 8'hc1);
		chk("standby kept", 8'h07, {5'h00, an, ev, oe});
		pwr(cmp_pkg::PWR_DOWN, 3'h0);
		pwr(cmp_pkg::PWR_ACTIVE, 3'h7);
	endtask : t_power
	task automatic t_off;
		wreg(cmp_pkg::OFS_CTRL, 8'h30);
		wreg(cmp_pkg::OFS_STAT, 8'h01);
		lvl(8'h40);
		lvl(8'hc0);
		chk("off event,valid", 8'h00, {6'h00, ev, vld});
		rchk(cmp_pkg::OFS_STAT, 8'h11, 8'h00);
	endtask : t_off
	////////////////////////////////////////////////////////////////
	task automatic end_of_test;
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : end_of_test
	// the tests take well under 3000 cycles
	initial
	begin
		#(40 * 20000);
		n_fail++;
		end_of_test();
	end
	initial
	begin
		repeat (10) @(posedge clk_in);
		nrst_in <= 1'b1;
		t_reset();
		t_config();
		t_edges();
		t_irq();
		t_power();
		t_off();
		end_of_test();
	end
endmodule : cmp_ctrl_tb
